//--- verilog/sspl_top.sv
`timescale 1ns/100ps
module sspl_top #(
	parameter int RST_TMO_0 = sspl_pkg::TMO_0_CYC,
	parameter int RST_TMO_1 = sspl_pkg::TMO_1_CYC,
	parameter int RST_TMO_2 = sspl_pkg::TMO_2_CYC,
	parameter int RST_TMO_3 = sspl_pkg::TMO_3_CYC,
	parameter int SCAN_SLOT = sspl_pkg::SCAN_SLOT_CYC
) (
	input  wire logic                          clk,
	input  wire logic                          rst_n,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [sspl_pkg::ADDR_W-1:0]   paddr,
	input  wire logic [31:0]                   pwdata,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr,
	input  wire logic                          manualResetIn,
	input  wire logic                          powerSequenceRequest,
	input  wire logic                          forceShutdownIn,
	input  wire logic                          busAddressStrap,
	input  wire logic [sspl_pkg::NUM_CH-1:0]   chanOverIn,
	input  wire logic [sspl_pkg::NUM_CH-1:0]   chanUnderIn,
	input  wire logic [sspl_pkg::NUM_CONV-1:0] convEnableReq,
	input  wire logic                          seqDoneIn,
	output sspl_pkg::sspl_pins_t               pins,
	output sspl_pkg::sspl_mode_t               mode,
	output logic                               seqOnStart,
	output logic                               seqOffStart,
	output logic      [3:0]                    scanChannel,
	output logic      [3:0]                    scanScale,
	output logic                               scanStrobe,
	output logic                               busAddressBit,
	output logic                               irq
);
	import sspl_pkg::*;

	sspl_state_t        st;
	sspl_state_t        next_st;
	logic [3:0]         pinSync;
	logic               mrActive;
	logic               reqActive;
	logic               fsActive;
	logic               powerReq;
	logic               marginOn;
	logic               monitoring;
	logic [NUM_CH-1:0]  tripped;
	logic               supplyTrip;
	logic               faultNow;
	logic               healthyNow;
	logic               rstTrigger;
	logic               rstNow;
	logic               busWrite;
	logic               busRead;
	logic [NUM_EVT-1:0] events;
	logic [NUM_EVT-1:0] clrBits;
	logic               pupOn;
	sspl_cmd_t          cmd;
	sspl_status_t       status;

	// Polarity map shared by inputs and open-drain outputs.
	function automatic logic polar(input logic a, input logic pol);
		return a ~^ pol;
	endfunction

	function automatic logic [RST_CNT_W-1:0] tmoLimit(input logic [1:0] sel);
		case (sel)
			2'h0: return RST_CNT_W'(RST_TMO_0 - 1);
			2'h1: return RST_CNT_W'(RST_TMO_1 - 1);
			2'h2: return RST_CNT_W'(RST_TMO_2 - 1);
			default: return RST_CNT_W'(RST_TMO_3 - 1);
		endcase
	endfunction

	sspl_sync #(
		.W(4)
	) u_sync (
		.clk  (clk),
		.rst_n(rst_n),
		.d    ({busAddressStrap, forceShutdownIn,
			powerSequenceRequest, manualResetIn}),
		.q    (pinSync)
	);

	assign mrActive   = polar(pinSync[0], st.ctrl.mrPol); // [R11]
	assign reqActive  = polar(pinSync[1], st.ctrl.reqPol); // [R11]
	assign fsActive   = polar(pinSync[2], st.ctrl.fsPol); // [R11]
	// Once the bus has taken over, the pin is ignored until cleared.
	assign powerReq   = st.busOverride ? st.busPower : reqActive; // [R9]
	assign monitoring = (st.mode == MODE_MONITOR);
	assign marginOn   = monitoring & st.ctrl.margin;
	assign tripped    = st.over | st.under;
	// Margining masks threshold results from reset and healthy.
	assign supplyTrip = (|(tripped & st.rstMask)) & ~marginOn; // [R4] [R16]
	assign faultNow   = |(tripped & st.faultMask & FAULT_CH_SEL); // [R5]
	assign healthyNow = monitoring &
		(marginOn | ~|(tripped & st.healthyMask)); // [R6] [R15] [R16]
	// Any mode other than monitor keeps reset asserted.
	assign rstTrigger = mrActive | supplyTrip | ~monitoring; // [R1] [R4] [R15]
	assign rstNow     = rstTrigger | ~st.rstReleased; // [R2]
	assign busWrite   = psel & penable & st.pready & pwrite;
	assign busRead    = psel & penable & ~st.pready;
	assign cmd        = sspl_cmd_t'(pwdata[2:0]);
	assign clrBits    = (busWrite && paddr == ADDR_IRQ_CLR) ?
		pwdata[NUM_EVT-1:0] : '0;

	always_comb begin
		status               = '0;
		status.strapDone     = st.strapDone;
		status.scanCh        = st.scanCh;
		status.marginOn      = marginOn;
		status.healthyActive = healthyNow;
		status.faultActive   = faultNow;
		status.rstActive     = rstNow;
		status.addrBit       = st.addrBit;
		status.busOverride   = st.busOverride;
		status.mode          = st.mode;
	end

	always_comb begin
		next_st             = st;
		next_st.seqOnStart  = 1'b0;
		next_st.seqOffStart = 1'b0;
		next_st.scanStrobe  = 1'b0;
		events              = '0;

		// Register writes take effect at the completing edge.
		if (busWrite) begin
			case (paddr)
				ADDR_CTRL:
					next_st.ctrl = sspl_ctrl_t'(pwdata[9:0]);
				ADDR_CMD: begin
					if (cmd.powerOn || cmd.powerOff) begin
						next_st.busOverride = 1'b1; // [R9]
						next_st.busPower    = cmd.powerOn;
					end else if (cmd.clear) begin
						next_st.busOverride = 1'b0; // [R9]
					end
				end
				ADDR_RST_MASK:
					next_st.rstMask = pwdata[NUM_CH-1:0];
				ADDR_FAULT_MASK:
					next_st.faultMask = pwdata[NUM_CH-1:0];
				ADDR_HEALTHY_MASK:
					next_st.healthyMask = pwdata[NUM_CH-1:0];
				ADDR_IRQ_EN:
					next_st.irqEn = pwdata[NUM_EVT-1:0];
				default: ;
			endcase
		end

		// One wait state: data and error are presented with pready.
		next_st.pready  = busRead;
		next_st.prdata  = '0;
		next_st.pslverr = 1'b0;
		if (busRead && !pwrite) begin
			case (paddr)
				ADDR_CTRL:         next_st.prdata = 32'(st.ctrl);
				ADDR_CMD:          next_st.prdata = '0;
				ADDR_RST_MASK:     next_st.prdata = 32'(st.rstMask);
				ADDR_FAULT_MASK:   next_st.prdata = 32'(st.faultMask);
				ADDR_HEALTHY_MASK: next_st.prdata = 32'(st.healthyMask);
				ADDR_STATUS:       next_st.prdata = 32'(status);
				ADDR_FLAGS:        next_st.prdata = 32'({st.under, st.over});
				ADDR_IRQ_STAT:     next_st.prdata = 32'(st.irqStat);
				ADDR_IRQ_EN:       next_st.prdata = 32'(st.irqEn);
				ADDR_IRQ_CLR:      next_st.prdata = '0;
				default:           next_st.pslverr = 1'b1;
			endcase
		end else if (busRead) begin
			case (paddr)
				ADDR_CTRL, ADDR_CMD, ADDR_RST_MASK, ADDR_FAULT_MASK,
				ADDR_HEALTHY_MASK, ADDR_STATUS, ADDR_FLAGS,
				ADDR_IRQ_STAT, ADDR_IRQ_EN, ADDR_IRQ_CLR:
					next_st.pslverr = 1'b0;
				default:
					next_st.pslverr = 1'b1;
			endcase
		end

		// Operating mode sequencing.
		case (st.mode)
			MODE_OFF: begin
				if (powerReq && !fsActive) begin
					next_st.mode       = MODE_SEQ_ON; // [R7]
					next_st.seqOnStart = 1'b1;
				end
			end
			MODE_SEQ_ON: begin
				if (fsActive) begin
					next_st.mode = MODE_OFF; // [R10]
				end else if (seqDoneIn) begin
					next_st.mode      = MODE_MONITOR;
					events[EVT_SEQ]   = 1'b1;
				end
			end
			MODE_MONITOR: begin
				if (fsActive) begin
					next_st.mode = MODE_OFF; // [R10]
				end else if (!powerReq) begin
					next_st.mode        = MODE_SEQ_OFF; // [R7]
					next_st.seqOffStart = 1'b1;
				end
			end
			MODE_SEQ_OFF: begin
				if (seqDoneIn || fsActive) begin
					next_st.mode    = MODE_OFF;
					events[EVT_SEQ] = seqDoneIn;
				end
			end
			default: next_st.mode = MODE_OFF;
		endcase

		// Channel scan runs only in monitor mode; results are dropped
		// otherwise so that stale trips cannot fire after a sequence.
		if (monitoring) begin
			if (st.scanCnt == SCAN_CNT_W'(SCAN_SLOT - 1)) begin
				next_st.scanCnt          = '0;
				next_st.scanStrobe       = 1'b1;
				next_st.over[st.scanCh]  = chanOverIn[st.scanCh]; // [R17]
				next_st.under[st.scanCh] = chanUnderIn[st.scanCh]; // [R17]
				next_st.scanCh = (st.scanCh == CH_LAST) ?
					4'h0 : st.scanCh + 4'h1; // [R17]
			end else begin
				next_st.scanCnt = st.scanCnt + SCAN_CNT_W'(1);
			end
		end else begin
			next_st.scanCnt = '0; // [R8]
			next_st.scanCh  = '0;
			next_st.over    = '0; // [R8]
			next_st.under   = '0; // [R8]
		end
		next_st.scanScale = fullScale(next_st.scanCh); // [R14]

		// Reset timeout restarts whenever any trigger is present.
		if (rstTrigger) begin
			next_st.rstCnt      = '0; // [R18]
			next_st.rstReleased = 1'b0; // [R1]
		end else if (!st.rstReleased) begin
			if (st.rstCnt >= tmoLimit(st.ctrl.tmoSel)) begin // [R3]
				next_st.rstReleased = 1'b1; // [R2]
			end else begin
				next_st.rstCnt = st.rstCnt + RST_CNT_W'(1);
			end
		end

		// Strap is taken once the synchroniser has settled after reset.
		if (!st.strapDone) begin
			if (st.strapCnt == 2'(STRAP_WAIT - 1)) begin
				next_st.strapDone = 1'b1;
				next_st.addrBit   = pinSync[3]; // [R13]
			end else begin
				next_st.strapCnt = st.strapCnt + 2'h1;
			end
		end

		// Open-drain pins: enable low pulls the pad low.
		next_st.pins.faultOut   = 1'b0;
		next_st.pins.healthyOut = 1'b0;
		next_st.pins.rstOut     = 1'b0;
		next_st.pins.pupOut     = '0;
		next_st.pins.faultOeN   = polar(faultNow, st.ctrl.faultPol); // [R12]
		next_st.pins.healthyOeN =
			polar(healthyNow, st.ctrl.healthyPol); // [R12]
		next_st.pins.rstOeN     = polar(rstNow, st.ctrl.rstPol); // [R12]
		for (int i = 0; i < NUM_CONV; i++) begin
			pupOn = convEnableReq[i] & ~fsActive &
				(next_st.mode != MODE_OFF); // [R10]
			next_st.pins.pupOeN[i] = polar(pupOn, st.ctrl.pupPol);
		end

		// Sticky events; a set in the clearing cycle survives.
		next_st.prevFault  = faultNow;
		next_st.prevRst    = rstNow;
		next_st.prevFs     = fsActive;
		events[EVT_FAULT]  = faultNow & ~st.prevFault;
		events[EVT_RST]    = rstNow & ~st.prevRst;
		events[EVT_FS]     = fsActive & ~st.prevFs;
		next_st.irqStat    = (st.irqStat & ~clrBits) | events;
		next_st.irq        = |(next_st.irqStat & next_st.irqEn);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st                 <= '0;
			st.ctrl            <= CTRL_RESET;
			st.rstMask         <= MASK_RESET;
			st.faultMask       <= MASK_RESET;
			st.healthyMask     <= MASK_RESET;
			st.mode            <= MODE_OFF;
			st.scanScale       <= FS_MULT_SENSE;
			st.prevRst         <= 1'b1;
			// The synchroniser leaves reset showing the active-low shutdown
			// pin asserted; starting high keeps that from logging an event.
			st.prevFs          <= 1'b1;
			st.pins.faultOeN   <= 1'b1;
			st.pins.healthyOeN <= 1'b1;
			st.pins.rstOeN     <= 1'b0;
			st.pins.pupOeN     <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign prdata        = st.prdata;
	assign pready        = st.pready;
	assign pslverr       = st.pslverr;
	assign pins          = st.pins;
	assign mode          = st.mode;
	assign seqOnStart    = st.seqOnStart;
	assign seqOffStart   = st.seqOffStart;
	assign scanChannel   = st.scanCh;
	assign scanScale     = st.scanScale;
	assign scanStrobe    = st.scanStrobe;
	assign busAddressBit = st.addrBit;
	assign irq           = st.irq;
endmodule

//--- verilog/sspl_pkg.sv
// Function
// R1: While manual reset is asserted, supervisor reset output is active.
// R2: Reset releases after timeout once manual reset and all triggers are gone.
// R3: Reset timeout selectable among 0.64 ms, 25 ms, 100 ms, 200 ms.
// R4: Reset active on any programmed supply or monitor fault, or manual reset.
// R5: Fault output active on programmed fault of aux inputs or temperature.
// R6: Healthy active only when all programmed inputs lie within limits.
// R7: Request assertion sequences supplies on; deassertion sequences them off.
// R8: Faults are not evaluated while an on or off sequence runs.
// R9: Bus power command overrides request pin until bus clear command.
// R10: Force shutdown immediately drops all four converter enables.
// R11: Manual reset, request and shutdown input polarities are programmable.
// R12: Fault, healthy, reset are open-drain with programmable active level.
// R13: Sampled address strap level forms one bus address bit.
// R14: Full scale is 4x reference for sense/chip, 12x bus, 2x aux.
// R15: During power-on sequencing healthy is inactive and reset active.
// R16: Margining forces healthy active and reset inactive despite thresholds.
// R17: Monitor mode scans all nine channels every 2 ms against thresholds.
// R18: Reset timeout restarts from zero when any trigger reasserts.
package sspl_pkg;

	localparam int ADDR_W     = 8;
	localparam int NUM_CH     = 9;
	localparam int NUM_CONV   = 4;
	localparam int NUM_EVT    = 4;
	localparam int RST_CNT_W  = 23;
	localparam int SCAN_CNT_W = 13;

	localparam int CLK_MHZ        = 25;
	localparam int TMO_0_US       = 640;
	localparam int TMO_1_US       = 25000;
	localparam int TMO_2_US       = 100000;
	localparam int TMO_3_US       = 200000;
	localparam int SCAN_PERIOD_US = 2000;
	localparam int TMO_0_CYC      = TMO_0_US * CLK_MHZ;
	localparam int TMO_1_CYC      = TMO_1_US * CLK_MHZ;
	localparam int TMO_2_CYC      = TMO_2_US * CLK_MHZ;
	localparam int TMO_3_CYC      = TMO_3_US * CLK_MHZ;
	localparam int SCAN_SLOT_CYC  = SCAN_PERIOD_US * CLK_MHZ / NUM_CH;
	localparam int STRAP_WAIT     = 3;

	localparam logic [ADDR_W-1:0] ADDR_CTRL         = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_CMD          = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_RST_MASK     = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_FAULT_MASK   = 8'h0c;
	localparam logic [ADDR_W-1:0] ADDR_HEALTHY_MASK = 8'h10;
	localparam logic [ADDR_W-1:0] ADDR_STATUS       = 8'h14;
	localparam logic [ADDR_W-1:0] ADDR_FLAGS        = 8'h18;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT     = 8'h1c;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_EN       = 8'h20;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_CLR      = 8'h24;

	localparam logic [3:0] CH_SENSE_LAST = 4'h3;
	localparam logic [3:0] CH_CHIP       = 4'h4;
	localparam logic [3:0] CH_BUS        = 4'h5;
	localparam logic [3:0] CH_AUX1       = 4'h6;
	localparam logic [3:0] CH_AUX2       = 4'h7;
	localparam logic [3:0] CH_LAST       = 4'h8;
	localparam logic [3:0] FS_MULT_SENSE = 4'h4;
	localparam logic [3:0] FS_MULT_BUS   = 4'hc;
	localparam logic [3:0] FS_MULT_AUX   = 4'h2;
	localparam logic [3:0] FS_MULT_TEMP  = 4'h1;

	localparam logic [NUM_CH-1:0] FAULT_CH_SEL = 9'h1c0;
	localparam logic [NUM_CH-1:0] MASK_RESET   = 9'h1ff;

	localparam int EVT_FAULT = 0;
	localparam int EVT_RST   = 1;
	localparam int EVT_SEQ   = 2;
	localparam int EVT_FS    = 3;

	typedef enum logic [1:0] {
		MODE_OFF     = 2'h0,
		MODE_SEQ_ON  = 2'h1,
		MODE_MONITOR = 2'h3,
		MODE_SEQ_OFF = 2'h2
	} sspl_mode_t;

	// Polarity bits: one means active high.
	typedef struct packed {
		logic       margin;
		logic [1:0] tmoSel;
		logic       pupPol;
		logic       rstPol;
		logic       healthyPol;
		logic       faultPol;
		logic       fsPol;
		logic       reqPol;
		logic       mrPol;
	} sspl_ctrl_t;

	localparam sspl_ctrl_t CTRL_RESET = 10'h040;

	typedef struct packed {
		logic clear;
		logic powerOff;
		logic powerOn;
	} sspl_cmd_t;

	typedef struct packed {
		logic       strapDone;
		logic [3:0] scanCh;
		logic       marginOn;
		logic       healthyActive;
		logic       faultActive;
		logic       rstActive;
		logic       addrBit;
		logic       busOverride;
		sspl_mode_t mode;
	} sspl_status_t;

	typedef struct packed {
		logic                faultOut;
		logic                faultOeN;
		logic                healthyOut;
		logic                healthyOeN;
		logic                rstOut;
		logic                rstOeN;
		logic [NUM_CONV-1:0] pupOut;
		logic [NUM_CONV-1:0] pupOeN;
	} sspl_pins_t;

	typedef struct packed {
		sspl_ctrl_t            ctrl;
		logic                  busOverride;
		logic                  busPower;
		logic [NUM_CH-1:0]     rstMask;
		logic [NUM_CH-1:0]     faultMask;
		logic [NUM_CH-1:0]     healthyMask;
		sspl_mode_t            mode;
		logic [NUM_CH-1:0]     over;
		logic [NUM_CH-1:0]     under;
		logic [3:0]            scanCh;
		logic [SCAN_CNT_W-1:0] scanCnt;
		logic                  scanStrobe;
		logic [3:0]            scanScale;
		logic [RST_CNT_W-1:0]  rstCnt;
		logic                  rstReleased;
		logic [1:0]            strapCnt;
		logic                  strapDone;
		logic                  addrBit;
		logic [NUM_EVT-1:0]    irqStat;
		logic [NUM_EVT-1:0]    irqEn;
		logic                  irq;
		logic                  prevFault;
		logic                  prevRst;
		logic                  prevFs;
		logic                  seqOnStart;
		logic                  seqOffStart;
		sspl_pins_t            pins;
		logic [31:0]           prdata;
		logic                  pready;
		logic                  pslverr;
	} sspl_state_t;

	function automatic logic [3:0] fullScale(input logic [3:0] ch);
		if (ch <= CH_SENSE_LAST || ch == CH_CHIP)
			return FS_MULT_SENSE;
		else if (ch == CH_BUS)
			return FS_MULT_BUS;
		else if (ch == CH_AUX1 || ch == CH_AUX2)
			return FS_MULT_AUX;
		else
			return FS_MULT_TEMP;
	endfunction

endpackage

//--- verilog/sspl_sync.sv
`timescale 1ns/100ps
module sspl_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta;

	// The first stage feeds only the second stage.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= '0;
			q    <= '0;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule

//--- tb/sspl_conv_model.sv
`timescale 1ns/100ps
module sspl_conv_model (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       slow,
	input  wire logic       seqOnStart,
	input  wire logic       seqOffStart,
	output logic      [3:0] convEnableReq,
	output logic            seqDoneIn
);
	logic [4:0] left;
	logic       goingOn;
	// A slow engine lets a shutdown land while a sequence is still running.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			left <= 5'h00;
			goingOn <= 1'b0;
			convEnableReq <= 4'h0;
			seqDoneIn <= 1'b0;
		end else begin
			seqDoneIn <= (left == 5'h01);
			if (seqOnStart || seqOffStart) begin
				left <= slow ? 5'h0c : 5'h02;
				goingOn <= seqOnStart;
			end else if (left != 5'h00) begin
				left <= left - 5'h01;
			end
			if (seqOnStart)
				convEnableReq <= 4'hf;
			else if (left == 5'h01 && !goingOn)
				convEnableReq <= 4'h0;
		end
	end
endmodule

//--- tb/sspl_chk_sva.sv
`timescale 1ns/100ps
module sspl_chk #(
	parameter int RST_TMO_0 = 20,
	parameter int SCAN_SLOT = 8
) (
	input wire logic                        clk,
	input wire logic                        rst_n,
	input wire logic                        psel,
	input wire logic                        penable,
	input wire logic                        pready,
	input wire logic                        manualResetIn,
	input wire logic                        forceShutdownIn,
	input wire logic [sspl_pkg::NUM_CH-1:0] chanOverIn,
	input wire logic                        seqDoneIn,
	input sspl_pkg::sspl_pins_t             pins,
	input sspl_pkg::sspl_mode_t             mode,
	input wire logic [3:0]                  scanChannel,
	input wire logic [3:0]                  scanScale,
	input wire logic                        scanStrobe
);
	import sspl_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic [7:0] quiet;
	logic [7:0] trip6;
	logic [3:0] expScale;
	function automatic logic [7:0] sat(input logic [7:0] v);
		return (v == 8'hff) ? v : v + 8'h01;
	endfunction
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			quiet <= 8'h00;
			trip6 <= 8'h00;
		end else begin
			quiet <= (manualResetIn && mode == MODE_MONITOR) ? sat(quiet) : 8'h00;
			trip6 <= (chanOverIn[6] && mode == MODE_MONITOR) ? sat(trip6) : 8'h00;
		end
	end
	always_comb begin
		case (scanChannel)
			4'h5: expScale = 4'hc;
			4'h6, 4'h7: expScale = 4'h2;
			4'h8: expScale = 4'h1;
			default: expScale = 4'h4;
		endcase
	end
	sequence fsHeld; !forceShutdownIn [*4]; endsequence
	sequence onDone;
		forceShutdownIn [*3] ##0 (mode == MODE_SEQ_ON && seqDoneIn);
	endsequence
	a_fs_drops_pup: assert property (
		fsHeld |=> pins.pupOeN == 4'h0 && mode == MODE_OFF)
		else $error("enables stayed on under shutdown");
	a_mr_forces_rst: assert property (
		!manualResetIn [*4] |=> !pins.rstOeN)
		else $error("reset pad not active under manual reset");
	a_on_to_mon: assert property (onDone |=> mode == MODE_MONITOR)
		else $error("sequence done did not enter monitor");
	a_seq_holds_rst: assert property (
		mode == MODE_SEQ_ON |-> !pins.rstOeN && pins.healthyOeN)
		else $error("pads wrong during power on");
	a_healthy_mon: assert property (
		(mode != MODE_MONITOR) [*2] |-> pins.healthyOeN)
		else $error("healthy active outside monitor");
	a_scale_match: assert property (scanStrobe |-> scanScale == expScale)
		else $error("full scale wrong for channel");
	a_scan_period: assert property (
		scanStrobe ##SCAN_SLOT (mode == MODE_MONITOR) |-> scanStrobe)
		else $error("scan slot spacing wrong");
	a_rst_timeout: assert property (
		$rose(pins.rstOeN) |-> quiet >= RST_TMO_0)
		else $error("reset released before timeout");
	a_fault_aux: assert property (
		trip6 > 9 * SCAN_SLOT + 3 |-> !pins.faultOeN)
		else $error("fault pad not active on aux trip");
	a_apb_wait: assert property (psel && penable && !pready |=> pready)
		else $error("bus answer not after one wait state");
endmodule
bind sspl_top sspl_chk #(.RST_TMO_0(RST_TMO_0), .SCAN_SLOT(SCAN_SLOT)) u_chk (
	.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
	.pready(pready), .manualResetIn(manualResetIn),
	.forceShutdownIn(forceShutdownIn), .chanOverIn(chanOverIn),
	.seqDoneIn(seqDoneIn), .pins(pins), .mode(mode),
	.scanChannel(scanChannel), .scanScale(scanScale), .scanStrobe(scanStrobe)
);

//--- tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
	import sspl_pkg::*;
	typedef struct packed {
		logic w; logic [7:0] a; logic [31:0] d; logic [31:0] exp; logic err;
	} sspl_row_t;
	localparam int TMO [4] = '{20, 40, 60, 80};
	localparam sspl_row_t ROWS [13] = '{
		'{1'b0, ADDR_IRQ_STAT, 32'h0, 32'h0, 1'b0},
		'{1'b0, ADDR_STATUS, 32'h0, 32'h1010, 1'b0},
		'{1'b0, ADDR_CTRL, 32'h0, 32'h40, 1'b0},
		'{1'b0, ADDR_RST_MASK, 32'h0, 32'h1ff, 1'b0},
		'{1'b0, ADDR_FAULT_MASK, 32'h0, 32'h1ff, 1'b0},
		'{1'b0, ADDR_HEALTHY_MASK, 32'h0, 32'h1ff, 1'b0},
		'{1'b1, ADDR_IRQ_EN, 32'hfa, 32'h0, 1'b0},
		'{1'b0, ADDR_IRQ_EN, 32'h0, 32'ha, 1'b0},
		'{1'b1, ADDR_IRQ_EN, 32'h0, 32'h0, 1'b0},
		'{1'b0, ADDR_CMD, 32'h0, 32'h0, 1'b0},
		'{1'b1, ADDR_STATUS, 32'hffff, 32'h0, 1'b0},
		'{1'b0, 8'h28, 32'h0, 32'h0, 1'b1},
		'{1'b1, 8'hfc, 32'h5, 32'h0, 1'b1}
	};
	logic        clk = 1'b0, rst_n = 1'b0, slow = 1'b0, rdErr;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdData;
	logic        pready, pslverr, irq, seqOn, seqOff, seqDone, strobe;
	logic        mrIn = 1'b1, reqIn = 1'b1, fsIn = 1'b1, addrBit, strap = 1'b0;
	logic [8:0]  overIn = 9'h000, underIn = 9'h000;
	logic [3:0]  convEn, scanCh, scale;
	sspl_pins_t  pins;
	sspl_mode_t  mode;
	int          mismatches = 0, comparisons = 0, waited;
	sspl_top #(.RST_TMO_0(TMO[0]), .RST_TMO_1(TMO[1]), .RST_TMO_2(TMO[2]),
		.RST_TMO_3(TMO[3]), .SCAN_SLOT(8)) dut (
		.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .manualResetIn(mrIn),
		.powerSequenceRequest(reqIn), .forceShutdownIn(fsIn),
		.busAddressStrap(strap), .chanOverIn(overIn), .chanUnderIn(underIn),
		.convEnableReq(convEn), .seqDoneIn(seqDone), .pins(pins), .mode(mode),
		.seqOnStart(seqOn), .seqOffStart(seqOff), .scanChannel(scanCh),
		.scanScale(scale), .scanStrobe(strobe), .busAddressBit(addrBit),
		.irq(irq));
	sspl_conv_model u_conv (.clk(clk), .rst_n(rst_n), .slow(slow),
		.seqOnStart(seqOn), .seqOffStart(seqOff), .convEnableReq(convEn),
		.seqDoneIn(seqDone));
	initial begin
		forever #20 clk = ~clk;
	end
	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic ok(input logic c);
		chk({31'h0, c}, 32'h1);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Pad bundle: reset, healthy and fault pad levels above the mode.
	function automatic logic [31:0] pinv();
		return {27'h0, pins.rstOeN, pins.healthyOeN, pins.faultOeN, mode};
	endfunction
	function automatic logic probe(input int s);
		case (s)
			0: return pins.rstOeN;
			1: return pins.healthyOeN;
			2: return pins.faultOeN;
			3: return seqOn;
			4: return seqOff;
			5: return mode == MODE_MONITOR;
			6: return mode == MODE_OFF;
			7: return irq;
			default: return mode == MODE_SEQ_ON;
		endcase
	endfunction
	task automatic waitFor(input int s, input logic v, input int lim);
		waited = 0;
		while (probe(s) !== v) begin
			@(posedge clk);
			waited++;
			if (waited > lim) begin
				mismatches++;
				$display("Error at %0t: wait %0h got %h expected %h", $time, s,
					probe(s), v);
				summarize();
			end
		end
	endtask
	// Ends with an idle cycle so that back-to-back calls never drive psel
	// twice in one time step.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rdData = prdata;
		rdErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50)
			waitFor(7, ~irq, 0);
		@(posedge clk);
	endtask
	initial begin
		cyc(8);
		rst_n <= 1'b1;
		@(posedge clk);
		chk(pinv(), 32'h0c);
		cyc(3);
		ok(addrBit === 1'b0);
		for (int i = 0; i < 13; i++) begin
			apb(ROWS[i].w, ROWS[i].a, ROWS[i].d);
			chk({31'h0, rdErr}, {31'h0, ROWS[i].err});
			if (!ROWS[i].w)
				chk(rdData, ROWS[i].exp);
		end
		reqIn <= 1'b0;
		waitFor(3, 1'b1, 10);
		chk(pinv(), 32'h0d);
		waitFor(5, 1'b1, 10);
		waitFor(0, 1'b1, 100);
		ok(waited >= TMO[0]);
		waitFor(1, 1'b0, 100);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, ADDR_CTRL, 32'h40 | (32'(i) << 7));
			mrIn <= 1'b0;
			waitFor(0, 1'b0, 5);
			cyc(3);
			mrIn <= 1'b1;
			waitFor(0, 1'b1, 200);
			ok(waited >= TMO[i] && waited <= TMO[i] + 8);
		end
		apb(1'b1, ADDR_CTRL, 32'h40);
		mrIn <= 1'b0;
		cyc(4);
		mrIn <= 1'b1;
		cyc(12);
		mrIn <= 1'b0;
		cyc(2);
		mrIn <= 1'b1;
		waitFor(0, 1'b1, 200);
		ok(waited >= TMO[0]);
		underIn <= 9'h001;
		waitFor(0, 1'b0, 100);
		chk(pinv(), 32'h0f);
		apb(1'b1, ADDR_CTRL, 32'h240);
		waitFor(0, 1'b1, 100);
		chk(pinv(), 32'h17);
		underIn <= 9'h000;
		apb(1'b1, ADDR_CTRL, 32'h40);
		cyc(80);
		waitFor(0, 1'b1, 100);
		apb(1'b1, ADDR_IRQ_EN, 32'h1);
		overIn <= 9'h040;
		waitFor(2, 1'b0, 100);
		waitFor(7, 1'b1, 4);
		cyc(80);
		apb(1'b0, ADDR_IRQ_STAT, 32'h0);
		chk(rdData & 32'h1, 32'h1);
		apb(1'b1, ADDR_IRQ_EN, 32'h0);
		ok(irq === 1'b0);
		overIn <= 9'h000;
		apb(1'b1, ADDR_IRQ_CLR, 32'hf);
		apb(1'b0, ADDR_IRQ_STAT, 32'h0);
		chk(rdData & 32'h1, 32'h0);
		waitFor(2, 1'b1, 100);
		waitFor(0, 1'b1, 200);
		apb(1'b1, ADDR_CTRL, 32'h79);
		cyc(3);
		chk(pinv(), 32'h1b);
		apb(1'b1, ADDR_CTRL, 32'h40);
		waitFor(0, 1'b1, 200);
		apb(1'b1, ADDR_CMD, 32'h1);
		reqIn <= 1'b1;
		cyc(6);
		ok(mode === MODE_MONITOR);
		apb(1'b1, ADDR_CMD, 32'h2);
		waitFor(6, 1'b1, 20);
		apb(1'b1, ADDR_CMD, 32'h1);
		waitFor(5, 1'b1, 20);
		apb(1'b1, ADDR_CMD, 32'h4);
		waitFor(4, 1'b1, 10);
		waitFor(6, 1'b1, 20);
		slow <= 1'b1;
		overIn <= 9'h040;
		reqIn <= 1'b0;
		waitFor(8, 1'b1, 10);
		cyc(3);
		chk({27'h0, pins.pupOeN, pins.faultOeN}, 32'h1f);
		fsIn <= 1'b0;
		waitFor(6, 1'b1, 6);
		chk({28'h0, pins.pupOeN}, 32'h0);
		fsIn <= 1'b1;
		reqIn <= 1'b1;
		overIn <= 9'h000;
		cyc(20);
		strap <= 1'b1;
		rst_n <= 1'b0;
		cyc(2);
		rst_n <= 1'b1;
		cyc(4);
		ok(addrBit === 1'b1);
		summarize();
	end
endmodule
